/* File: rtl/dsd_pkg.sv */
/*
  Constants, register map and carrier types of the device status and
  diagnostics block. Assumes a single 25 MHz clock domain.

  // What this block does
  // - Modem power-on command powers modem 300 s, shows countdown, then off.
  // - Dispatch call steps power-up, init, connect, sends frame, hangs up.
  // - Battery readout gives percent and voltage; absent battery gives comm error.
  // - Freeze command holds displayed measured values constant.
  // - Summary latches every status bit active since last summary reset.
  // - Summary reset from keypad or software loads present current status.
  // - Summary reset only with service switch on; else refused with message.
  // - Device test runs seconds, leaves measurement alone, ignores switch, lists faults.
  // - Full test daily, swap test hourly, also at power-on and on request.
  // - Indicator shows error if any error bit, else warning, else ok.
  // - Checksum faults set bits 0, 1, 2, 22 and 23.
  // - Memory faults set bits 3, 26 and 27.
  // - Full change archive sets bit 5 and blocks parameter changes.
  // - Unauthorised sensor swap or parameter change sets bit 6.
  // - Sensor communication failure sets bit 7; transducer fault sets bit 8.
  // - Main battery near 10 percent sets bit 9; disconnected sets bit 19.
  // - Clock correction beyond 2 h sets bit 4.
  // - Compressibility table failure sets bit 10; out of scope sets bit 17.
  // - Channel one range and fault bits 32, 33, 36, 37, 38, 41.
  // - Channel two range and fault bits 48, 49, 52, 53, 54, 57.
  // - Encoder fault bit 20, modem battery bit 15, barometer fault bit 46.
  // - Service switch on shows as warning bit 63 and gates summary reset.
*/
package dsd_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CUR_LO = 8'h08;
  localparam logic [7:0] REG_CUR_HI = 8'h0C;
  localparam logic [7:0] REG_SUM_LO = 8'h10;
  localparam logic [7:0] REG_SUM_HI = 8'h14;
  localparam logic [7:0] REG_COUNT = 8'h18;
  localparam logic [7:0] REG_MBAT = 8'h1C;
  localparam logic [7:0] REG_TEST_LO = 8'h20;
  localparam logic [7:0] REG_TEST_HI = 8'h24;

  // Command bit positions in the control register
  localparam int CMD_MODEM_ON = 0;
  localparam int CMD_CALL = 1;
  localparam int CMD_BAT = 2;
  localparam int CMD_FREEZE = 3;
  localparam int CMD_UNFREEZE = 4;
  localparam int CMD_SUM_RESET = 5;
  localparam int CMD_DEV_TEST = 6;

  // Status word bit positions
  localparam int BIT_ARCHIVE_FULL = 5;
  localparam int BIT_SERVICE_SW = 63;

  // Error and warning bit sets of the 64-bit status word
  localparam logic [63:0] ERR_MASK = 64'h02734273_0CDA87FF;
  localparam logic [63:0] WRN_MASK = 64'hE18C3D8C_33057800;

  // Reset values
  localparam logic [63:0] STATUS_RST = 64'h0;
  localparam logic [31:0] WORD_RST = 32'h0;

  // Timing
  localparam longint SECOND_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 40;
  localparam int unsigned CYC_PER_SEC = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam logic [8:0] MODEM_ON_S = 9'd300;
  localparam logic [3:0] TEST_S = 4'h3;
  localparam logic [11:0] HOUR_S = 12'd3600;
  localparam logic [16:0] DAY_S = 17'd86400;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Short summary indicator
  typedef enum logic [1:0] {IND_OK, IND_WRN, IND_ERR} dsd_ind_t;

  // Modem sequencer states
  typedef enum logic [2:0] {
    M_OFF, M_WINDOW, M_PWRUP, M_INIT, M_CONNECT, M_SEND, M_HANGUP
  } dsd_mstate_t;

  // Keypad command pulses
  typedef struct packed {
    logic modem_on;
    logic call;
    logic bat;
    logic freeze;
    logic unfreeze;
    logic sum_reset;
    logic dev_test;
  } dsd_key_t;

  // Modem progress reports
  typedef struct packed {
    logic powered;
    logic init_done;
    logic connected;
    logic frame_done;
    logic hung_up;
  } dsd_modem_in_t;

  // Modem requests
  typedef struct packed {
    logic power;
    logic init;
    logic dial;
    logic send_frame;
    logic hangup;
  } dsd_modem_out_t;

  // Modem battery report
  typedef struct packed {
    logic valid;
    logic present;
    logic [7:0] pct;
    logic [15:0] mv;
  } dsd_bat_t;

endpackage

/* File: rtl/dsd_status_diag.sv */
/*
  Device status and diagnostics: current and summary status words,
  indicator, self-test scheduler, modem service sequencer, modem battery
  readout and value freeze, with an AXI4-Lite register slave.
  Assumes fault conditions arrive as synchronous live levels and that the
  modem side reports progress as synchronous levels or pulses.
*/
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module dsd_status_diag import dsd_pkg::*; #(
  parameter int unsigned TICK_CYCLES = CYC_PER_SEC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Fault conditions and switch
  input wire logic [63:0] fault_cond,
  input wire logic service_switch,
  // Keypad
  input wire dsd_key_t key_cmd,
  // Modem
  input wire dsd_modem_in_t modem_in,
  output dsd_modem_out_t modem_out,
  input wire dsd_bat_t modem_bat,
  output logic bat_req,
  // Measured values
  input wire logic [31:0] live_value,
  output logic [31:0] shown_value,
  // Diagnostics outputs
  output dsd_ind_t indicator,
  output logic param_lock,
  output logic refuse_msg,
  output logic full_test_run,
  output logic swap_test_req,
  output logic [8:0] modem_countdown
);

  // Address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      REG_CTRL, REG_STAT, REG_CUR_LO, REG_CUR_HI, REG_SUM_LO, REG_SUM_HI,
      REG_COUNT, REG_MBAT, REG_TEST_LO, REG_TEST_HI: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Write channel: both halves taken together, one response outstanding
  logic wr_take;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic [6:0] sw_cmd;
  assign wr_take = awvalid && wvalid && !bvalid;
  assign awready = wr_take;
  assign wready = wr_take;

  always_comb begin
    next_bvalid = bvalid;
    next_bresp = bresp;
    sw_cmd = 7'h00;
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_take) begin
      next_bvalid = 1'b1;
      next_bresp = mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (awaddr == REG_CTRL && wstrb[0]) begin
        sw_cmd = wdata[6:0];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  // Commands from keypad and from software are merged
  logic c_modem_on, c_call, c_bat, c_freeze, c_unfreeze, c_sum, c_test;
  assign c_modem_on = key_cmd.modem_on | sw_cmd[CMD_MODEM_ON];
  assign c_call = key_cmd.call | sw_cmd[CMD_CALL];
  assign c_bat = key_cmd.bat | sw_cmd[CMD_BAT];
  assign c_freeze = key_cmd.freeze | sw_cmd[CMD_FREEZE];
  assign c_unfreeze = key_cmd.unfreeze | sw_cmd[CMD_UNFREEZE];
  assign c_sum = key_cmd.sum_reset | sw_cmd[CMD_SUM_RESET];
  assign c_test = key_cmd.dev_test | sw_cmd[CMD_DEV_TEST];

  // Second tick shared by all timers
  logic [31:0] tick_cnt, next_tick_cnt;
  logic sec_tick;
  assign sec_tick = (tick_cnt == TICK_CYCLES - 1);

  always_comb begin
    next_tick_cnt = sec_tick ? 32'h0 : tick_cnt + 32'h1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // Current status follows live conditions; error and warning bits only
  logic [63:0] cur_next_w;
  always_comb begin
    cur_next_w = fault_cond & (ERR_MASK | WRN_MASK);
    cur_next_w[BIT_SERVICE_SW] = service_switch;
  end

  // Summary status with gated reset; refusal message held until next try
  logic [63:0] cur, sum, next_sum;
  logic next_refuse;
  always_comb begin
    next_sum = sum | cur;
    next_refuse = refuse_msg;
    if (c_sum) begin
      if (service_switch) begin
        next_sum = cur;
        next_refuse = 1'b0;
      end else begin
        next_refuse = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur <= STATUS_RST;
      sum <= STATUS_RST;
      refuse_msg <= 1'b0;
    end else begin
      cur <= cur_next_w;
      sum <= next_sum;
      refuse_msg <= next_refuse;
    end
  end

  // Indicator from the summary, error before warning
  always_comb begin
    if (|(sum & ERR_MASK)) begin
      indicator = IND_ERR;
    end else if (|(sum & WRN_MASK)) begin
      indicator = IND_WRN;
    end else begin
      indicator = IND_OK;
    end
  end

  // Full archive blocks parameter changes but nothing else
  assign param_lock = cur[BIT_ARCHIVE_FULL];

  // Test scheduler: power-on, daily and requested full tests, hourly swap
  logic boot, next_boot;
  logic [16:0] day_cnt, next_day_cnt;
  logic [11:0] hour_cnt, next_hour_cnt;
  logic [3:0] test_left, next_test_left;
  logic next_full, next_swap;
  logic [63:0] test_res, next_test_res;

  always_comb begin
    next_boot = 1'b0;
    next_day_cnt = day_cnt;
    next_hour_cnt = hour_cnt;
    next_test_left = test_left;
    next_full = full_test_run;
    next_swap = 1'b0;
    next_test_res = test_res;
    if (sec_tick) begin
      next_day_cnt = (day_cnt == DAY_S - 17'd1) ? 17'd0 : day_cnt + 17'd1;
      next_hour_cnt = (hour_cnt == HOUR_S - 12'd1) ? 12'd0 :
                      hour_cnt + 12'd1;
      if (hour_cnt == HOUR_S - 12'd1) begin
        next_swap = 1'b1;
      end
      if (full_test_run) begin
        next_test_left = test_left - 4'h1;
        if (test_left == 4'h1) begin
          next_full = 1'b0;
          next_test_res = cur;
        end
      end
    end
    // Switch position is not looked at here
    if (!full_test_run && (boot || c_test ||
        (sec_tick && day_cnt == DAY_S - 17'd1))) begin
      next_full = 1'b1;
      next_test_left = TEST_S;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot <= 1'b1;
      day_cnt <= 17'd0;
      hour_cnt <= 12'd0;
      test_left <= 4'h0;
      full_test_run <= 1'b0;
      swap_test_req <= 1'b0;
      test_res <= STATUS_RST;
    end else begin
      boot <= next_boot;
      day_cnt <= next_day_cnt;
      hour_cnt <= next_hour_cnt;
      test_left <= next_test_left;
      full_test_run <= next_full;
      swap_test_req <= next_swap;
      test_res <= next_test_res;
    end
  end

  // Modem sequencer; a new command is ignored while one is running
  dsd_mstate_t mstate, next_mstate;
  logic [8:0] next_count;
  always_comb begin
    next_mstate = mstate;
    next_count = modem_countdown;
    case (mstate)
      M_OFF: begin
        if (c_modem_on) begin
          next_mstate = M_WINDOW;
          next_count = MODEM_ON_S;
        end else if (c_call) begin
          next_mstate = M_PWRUP;
        end
      end
      M_WINDOW: begin
        if (sec_tick) begin
          next_count = modem_countdown - 9'd1;
          if (modem_countdown == 9'd1) begin
            next_mstate = M_OFF;
          end
        end
      end
      M_PWRUP: if (modem_in.powered) next_mstate = M_INIT;
      M_INIT: if (modem_in.init_done) next_mstate = M_CONNECT;
      M_CONNECT: if (modem_in.connected) next_mstate = M_SEND;
      // Acceptance is up to the far end; only completion is awaited
      M_SEND: if (modem_in.frame_done) next_mstate = M_HANGUP;
      M_HANGUP: if (modem_in.hung_up) next_mstate = M_OFF;
      default: next_mstate = M_OFF;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mstate <= M_OFF;
      modem_countdown <= 9'd0;
    end else begin
      mstate <= next_mstate;
      modem_countdown <= next_count;
    end
  end

  // Modem requests decoded from the sequencer state
  always_comb begin
    modem_out.power = (mstate != M_OFF);
    modem_out.init = (mstate == M_INIT);
    modem_out.dial = (mstate == M_CONNECT);
    modem_out.send_frame = (mstate == M_SEND);
    modem_out.hangup = (mstate == M_HANGUP);
  end

  // Modem battery readout: request pulse, then latched report
  logic [31:0] mbat, next_mbat;
  logic next_bat_req;
  always_comb begin
    next_bat_req = c_bat;
    next_mbat = mbat;
    if (modem_bat.valid) begin
      if (modem_bat.present) begin
        next_mbat = {8'h00, modem_bat.mv, modem_bat.pct};
      end else begin
        next_mbat = 32'h80000000;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bat_req <= 1'b0;
      mbat <= WORD_RST;
    end else begin
      bat_req <= next_bat_req;
      mbat <= next_mbat;
    end
  end

  // Freeze holds the shown value; live path otherwise
  logic frozen, next_frozen;
  logic [31:0] next_shown;
  always_comb begin
    next_frozen = frozen;
    if (c_freeze) begin
      next_frozen = 1'b1;
    end else if (c_unfreeze) begin
      next_frozen = 1'b0;
    end
    next_shown = frozen ? shown_value : live_value;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frozen <= 1'b0;
      shown_value <= WORD_RST;
    end else begin
      frozen <= next_frozen;
      shown_value <= next_shown;
    end
  end

  // Status word for software
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0;
    stat_word[1:0] = indicator;
    stat_word[2] = refuse_msg;
    stat_word[3] = full_test_run;
    stat_word[6:4] = mstate;
    stat_word[7] = frozen;
    stat_word[8] = param_lock;
    stat_word[9] = service_switch;
  end

  // Read channel: one cycle to answer, held until taken
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  assign arready = !rvalid;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        REG_CTRL: next_rdata = {28'h0, frozen, 3'h0};
        REG_STAT: next_rdata = stat_word;
        REG_CUR_LO: next_rdata = cur[31:0];
        REG_CUR_HI: next_rdata = cur[63:32];
        REG_SUM_LO: next_rdata = sum[31:0];
        REG_SUM_HI: next_rdata = sum[63:32];
        REG_COUNT: next_rdata = {23'h0, modem_countdown};
        REG_MBAT: next_rdata = mbat;
        REG_TEST_LO: next_rdata = test_res[31:0];
        REG_TEST_HI: next_rdata = test_res[63:32];
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= WORD_RST;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

endmodule

/* File: tb/dsd_status_diag_props.sv */
/*
  Concurrent checks on the ports of the status and diagnostics block.
  Assumes one clock domain; bound into every instance of the block.
*/
`timescale 1ns/10ps
module dsd_status_diag_props import dsd_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Inputs watched
  input wire logic [63:0] fault_cond,
  input wire logic service_switch,
  input wire dsd_key_t key_cmd,
  // Outputs watched
  input wire dsd_modem_out_t modem_out,
  input wire logic bat_req,
  input wire logic [31:0] shown_value,
  input wire dsd_ind_t indicator,
  input wire logic param_lock,
  input wire logic refuse_msg,
  input wire logic full_test_run,
  input wire logic swap_test_req,
  input wire logic [8:0] modem_countdown
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Error reaches indicator via current, then summary
  property p_err_ind;
    |(fault_cond & ERR_MASK) |-> ##2 indicator == IND_ERR;
  endproperty
  a_err_ind: assert property (p_err_ind)
    else $error("indicator not error");

  property p_lock;
    fault_cond[BIT_ARCHIVE_FULL] |=> param_lock;
  endproperty
  a_lock: assert property (p_lock)
    else $error("parameter lock missing");

  property p_refuse;
    key_cmd.sum_reset && !service_switch |=> refuse_msg;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("summary reset not refused");

  property p_accept;
    key_cmd.sum_reset && service_switch |=> !refuse_msg;
  endproperty
  a_accept: assert property (p_accept)
    else $error("summary reset not accepted");

  // Window starts only from an idle modem
  property p_win_load;
    key_cmd.modem_on && modem_out == '0 && modem_countdown == 9'h0
      |=> modem_countdown == MODEM_ON_S;
  endproperty
  a_win_load: assert property (p_win_load)
    else $error("countdown not loaded");

  // Count only ever steps down by one second
  property p_win_dec;
    $changed(modem_countdown) && $past(modem_countdown) != 9'h0
      |-> modem_countdown == $past(modem_countdown) - 9'h1;
  endproperty
  a_win_dec: assert property (p_win_dec)
    else $error("countdown step wrong");

  property p_win_off;
    $past(modem_countdown) == 9'h1 && modem_countdown == 9'h0
      |-> ##[0:1] !modem_out.power;
  endproperty
  a_win_off: assert property (p_win_off)
    else $error("modem left powered");

  property p_bat;
    key_cmd.bat |=> bat_req;
  endproperty
  a_bat: assert property (p_bat)
    else $error("battery request missing");

  property p_freeze;
    key_cmd.freeze ##1 !key_cmd.unfreeze |=> $stable(shown_value);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("shown value moved");

  property p_test;
    key_cmd.dev_test && !full_test_run |=> full_test_run;
  endproperty
  a_test: assert property (p_test)
    else $error("device test not started");

  property p_swap;
    swap_test_req |=> !swap_test_req;
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap request too long");
endmodule

bind dsd_status_diag dsd_status_diag_props dsd_status_diag_props_i (.*);

/* File: tb/dsd_modem_model.sv */
/*
  Modem and modem battery model at the far side of the block.
  Assumes the block's clock; answers every request one cycle later.
*/
`timescale 1ns/10ps
module dsd_modem_model import dsd_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Block side
  input wire dsd_modem_out_t modem_out,
  input wire logic bat_req,
  output dsd_modem_in_t modem_in,
  output dsd_bat_t modem_bat,
  // Bench side
  input wire logic bat_present,
  output logic [4:0] steps
);
  // Progress echoes requests; a step counts only after the one before
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      modem_in <= '0;
      modem_bat <= '0;
      steps <= 5'h0;
    end else begin
      modem_in <= dsd_modem_in_t'(modem_out);
      steps <= steps | (modem_out & {1'b1, steps[4:1]});
      if (bat_req && bat_present) begin
        modem_bat <= {2'b11, 8'h4B, 16'h0E10};
      end else if (bat_req) begin
        modem_bat <= {2'b10, 24'h5A5A5A}; // No battery, no charge data
      end else begin
        // Idle payload toggles so a stale read never matches
        modem_bat <= {2'b00, ~modem_bat[23:0]};
      end
    end
  end
endmodule

/* File: tb/dsd_status_diag_tb.sv */
/*
  Self-checking bench of the status and diagnostics block.
  Assumes the modem model and the bound checker are compiled with it.
*/
`timescale 1ns/10ps
module dsd_status_diag_tb import dsd_pkg::*; ;
  localparam int T = 2;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, bat_req, param_lock;
  logic refuse_msg, full_test_run, swap_test_req, service_switch;
  logic bat_present;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, shown_value, d;
  logic [31:0] live_value = 32'h0;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [63:0] fault_cond, e, v;
  logic [8:0] modem_countdown;
  logic [4:0] steps;
  dsd_key_t key_cmd;
  dsd_modem_in_t modem_in;
  dsd_modem_out_t modem_out;
  dsd_bat_t modem_bat;
  dsd_ind_t indicator;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  int cyc = 0;
  int eb[32] = '{0, 1, 2, 22, 23, 3, 26, 27, 5, 6, 7, 8, 9, 19, 4, 10,
    17, 32, 33, 36, 37, 38, 41, 48, 49, 52, 53, 54, 57, 20, 15, 46};

  dsd_status_diag #(.TICK_CYCLES(T)) dsd_status_diag_i (.*);
  dsd_modem_model dsd_modem_model_i (.*);

  initial begin
    forever #20 clock = ~clock;
  end

  // Moving measured value and cycles since reset release
  always @(posedge clock) begin
    live_value <= live_value + 32'h1;
    cyc <= rst ? 0 : cyc + 1;
  end

  task automatic chk(string s, logic [63:0] x, logic [63:0] g);
    samples_checked++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, x, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Address and data offered together, released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock);
    awaddr <= a;
    wdata <= x;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge clock);
    while (!awready) @(posedge clock);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (!bvalid) @(posedge clock);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clock);
    while (!arready) @(posedge clock);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clock);
    x = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd64(input logic [7:0] a, output logic [63:0] x);
    rd(a, x[31:0]);
    rd(a + 8'h4, x[63:32]);
  endtask

  // One-cycle keypad pulse
  task automatic key(input int b);
    @(posedge clock);
    key_cmd <= dsd_key_t'(7'h40 >> b);
    @(posedge clock);
    key_cmd <= '0;
  endtask

  task automatic settle(input int k);
    repeat (k) @(negedge clock);
  endtask

  task automatic ended(string s);
    $display("test %s ended", s);
  endtask

  // Watchdog sized well past the hourly swap test
  initial begin
    repeat (3700 * T + 6000) @(posedge clock);
    $display("[ERR] watchdog exp finish got hang");
    error_cnt++;
    give_verdict;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    fault_cond = '0;
    service_switch = 1'b0;
    bat_present = 1'b1;
    key_cmd = '0;
    e = '0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    settle(2);
    chk("boot_test", 1, full_test_run);
    chk("ind_ok", IND_OK, indicator);
    n = 0;
    while (full_test_run && n < 50 * T) begin settle(1); n++; end
    chk("boot_end", 0, full_test_run);
    // All listed error bits at once
    foreach (eb[i]) e[eb[i]] = 1'b1;
    @(posedge clock);
    fault_cond <= e;
    rd64(REG_CUR_LO, v);
    chk("cur_err", e, v);
    chk("lock", 1, param_lock);
    rd(REG_STAT, d);
    chk("stat_ind", IND_ERR, d[1:0]);
    @(posedge clock);
    fault_cond <= '0;
    rd64(REG_CUR_LO, v);
    chk("cur_clear", 0, v);
    rd64(REG_SUM_LO, v);
    chk("sum_sticky", e, v);
    ended("status");
    key(CMD_SUM_RESET);
    settle(1);
    chk("refused", 1, refuse_msg);
    rd64(REG_SUM_LO, v);
    chk("sum_kept", e, v);
    @(posedge clock);
    service_switch <= 1'b1;
    key(CMD_SUM_RESET);
    settle(2);
    chk("accepted", 0, refuse_msg);
    rd64(REG_SUM_LO, v);
    chk("sum_load", 64'h80000000_00000000, v);
    chk("ind_wrn", IND_WRN, indicator);
    @(posedge clock);
    service_switch <= 1'b0;
    rd(8'h40, d);
    chk("unmapped", {RESP_SLVERR, 32'h0}, {resp, d});
    ended("summary");
    key(CMD_MODEM_ON);
    settle(1);
    chk("win_load", {1'b1, MODEM_ON_S}, {modem_out.power, modem_countdown});
    n = 0;
    while (modem_countdown != 9'h0 && n < 400 * T) begin settle(1); n++; end
    settle(2);
    chk("win_len", 1, n >= 299 * T && n <= 301 * T);
    chk("win_off", 0, modem_out.power);
    wr(REG_CTRL, 32'h1 << CMD_CALL);
    chk("wr_resp", RESP_OKAY, resp);
    n = 0;
    while ((steps !== 5'h1F || modem_out.power) && n < 200) begin
      settle(1);
      n++;
    end
    settle(2);
    chk("call_steps", 5'h1F, steps);
    rd(REG_STAT, d);
    chk("call_idle", 0, {modem_out, d[6:4]});
    ended("modem");
    key(CMD_BAT);
    settle(4);
    rd(REG_MBAT, d);
    chk("bat", 32'h000E104B, d);
    @(posedge clock);
    bat_present <= 1'b0;
    key(CMD_BAT);
    settle(4);
    rd(REG_MBAT, d);
    chk("bat_absent", 32'h80000000, d);
    ended("battery");
    key(CMD_FREEZE);
    settle(2);
    d = shown_value;
    settle(4);
    chk("frozen", d, shown_value);
    key(CMD_UNFREEZE);
    settle(2);
    chk("unfrozen", live_value - 32'h1, shown_value);
    ended("freeze");
    @(posedge clock);
    fault_cond <= 64'h80;
    key(CMD_DEV_TEST);
    settle(1);
    chk("test_run", 1, full_test_run);
    n = 0;
    while (full_test_run && n < 50 * T) begin settle(1); n++; end
    chk("test_len", 1, n >= 2 * T && n <= 4 * T);
    rd64(REG_TEST_LO, v);
    chk("test_list", 64'h80, v);
    ended("devtest");
    n = 0;
    while (!swap_test_req && n < 3700 * T) begin settle(1); n++; end
    chk("hourly", 1, cyc >= 3600 * T - 2 && cyc <= 3600 * T + 2);
    ended("schedule");
    give_verdict;
  end
endmodule
